// ---- card_spi_pkg.sv ----
package card_spi_pkg;
  localparam int BYTE_W = 8;
  localparam int WORD_W = BYTE_W + 1;
  localparam int FIFO_DEPTH = 16;
  localparam int LAST_BIT = BYTE_W;
  localparam logic [2:0] FINAL_BIT_INDEX = 3'h7;
  localparam logic [2:0] FIRST_BIT_INDEX = 3'h0;
  localparam logic SELECT_IDLE = 1'b1;
  localparam logic CLOCK_IDLE = 1'b0;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_wait_byte = 2'b01,
    st_shift = 2'b11,
    st_finish = 2'b10
  } link_state_t;
endpackage

// ---- byte_stream_if.sv ----
`timescale 1ns/1ns
interface byte_stream_if #(parameter int WIDTH = 9);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

// ---- stream_fifo.sv ----
`timescale 1ns/1ns
module stream_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Filling side
  byte_stream_if.sink fill,
  // Draining side
  byte_stream_if.source drain
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic full;

  wire push = fill.valid & ~full;
  wire pop = drain.ready & (count != '0);
  wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // Ready comes from a registered full flag; the top registers it once more before tx_ready_o.
  assign fill.ready = ~full;
  assign drain.valid = (count != '0);
  assign drain.data = mem[rd_ptr];

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= fill.data;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      full <= 1'b0;
    end
    else
    begin
      wr_ptr <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
      rd_ptr <= pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
      count <= next_count;
      full <= (next_count == (AW+1)'(DEPTH));
    end
  end
endmodule

// ---- memory_card_spi_host.sv ----
`timescale 1ns/1ns
module memory_card_spi_host
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Link clock sources, both from outside this domain
  input wire logic fast_source_clock_i,
  input wire logic slow_source_clock_i,
  // Control
  input wire logic enable_i,
  input wire logic init_active_i,
  // Transmit stream: bit 8 marks the last byte of a sequence
  input wire logic tx_valid_i,
  input wire logic [card_spi_pkg::WORD_W-1:0] tx_data_i,
  output logic tx_ready_o,
  // Receive stream
  output logic rx_valid_o,
  output logic [card_spi_pkg::BYTE_W-1:0] rx_data_o,
  // Card pins
  output logic card_select_n_o,
  output logic card_serial_clock_o,
  output logic card_data_in_o,
  input wire logic card_data_out_i,
  input wire logic card_detect_n_i,
  input wire logic write_protect_n_i,
  // Status
  output logic busy_o,
  output logic card_present_o,
  output logic write_protected_o
);
  import card_spi_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Bit order: fast clock, slow clock, card data, detect, write protect.
  localparam int NSYNC = 5;
  wire [NSYNC-1:0] raw_in = {write_protect_n_i, card_detect_n_i, card_data_out_i,
                             slow_source_clock_i, fast_source_clock_i};
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          sync_a[gi] <= 1'b1;
          sync_b[gi] <= 1'b1;
        end
        else
        begin
          sync_a[gi] <= raw_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  wire fast_s = sync_b[0];
  wire slow_s = sync_b[1];
  wire miso_s = sync_b[2];
  wire detect_n_s = sync_b[3];
  wire protect_n_s = sync_b[4];

  // ----------------------------------------------------------------
  // Bit tick from the selected source
  // ----------------------------------------------------------------
  // Changing init_active_i mid-byte may stretch or shorten one half period;
  // callers switch sources only while the link is idle.
  wire source_sel = init_active_i ? slow_s : fast_s;
  logic source_prev;
  wire tick = source_sel & ~source_prev;

  // ----------------------------------------------------------------
  // Transmit FIFO
  // ----------------------------------------------------------------
  byte_stream_if #(.WIDTH(WORD_W)) fill_bus ();
  byte_stream_if #(.WIDTH(WORD_W)) drain_bus ();

  assign fill_bus.valid = tx_valid_i;
  assign fill_bus.data = tx_data_i;

  stream_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .fill(fill_bus.sink),
    .drain(drain_bus.source)
  );

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  link_state_t state;
  link_state_t next_state;
  logic [BYTE_W-1:0] tx_shift;
  logic [BYTE_W-1:0] rx_shift;
  logic [2:0] bit_index;
  logic last_byte;
  logic lead;

  wire byte_ready = drain_bus.valid;
  wire rise_tick = (state == st_shift) & tick & ~card_serial_clock_o & ~lead;
  wire fall_tick = (state == st_shift) & tick & card_serial_clock_o;
  wire byte_end = fall_tick & (bit_index == FINAL_BIT_INDEX);
  wire chain_next = byte_end & ~last_byte & enable_i & byte_ready;
  wire start_new = (state == st_idle) & enable_i & byte_ready;
  wire resume = (state == st_wait_byte) & enable_i & byte_ready;
  wire load_byte = start_new | resume | chain_next;
  wire [BYTE_W-1:0] load_data = drain_bus.data[BYTE_W-1:0];

  assign drain_bus.ready = load_byte;

  // A new sequence lets one tick pass before its first rising edge. The card's
  // first bit then has time to cross the data synchroniser and is not missed.
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      lead <= 1'b0;
    end
    else
    begin
      lead <= start_new | (lead & ~tick);
    end
  end

  always_comb
  begin
    next_state = state;
    case (state)
      st_idle:
        next_state = start_new ? st_shift : st_idle;
      st_wait_byte:
        if (resume)
          next_state = st_shift;
        else if (!enable_i)
          next_state = st_finish;
        else
          next_state = st_wait_byte;
      st_shift:
        if (byte_end)
        begin
          // A byte that started always ends before disable takes effect.
          if (last_byte || !enable_i)
            next_state = st_finish;
          else if (byte_ready)
            next_state = st_shift;
          else
            next_state = st_wait_byte;
        end
      st_finish:
        next_state = tick ? st_idle : st_finish;
      default:
        next_state = st_idle;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state <= st_idle;
      source_prev <= 1'b1;
      tx_shift <= '0;
      rx_shift <= '0;
      bit_index <= FIRST_BIT_INDEX;
      last_byte <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_data_o <= '0;
      card_select_n_o <= SELECT_IDLE;
      card_serial_clock_o <= CLOCK_IDLE;
      card_data_in_o <= 1'b1;
      busy_o <= 1'b0;
      tx_ready_o <= 1'b0;
      card_present_o <= 1'b0;
      write_protected_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      source_prev <= source_sel;
      tx_ready_o <= ~fill_bus.ready ? 1'b0 : 1'b1;
      card_present_o <= ~detect_n_s;
      write_protected_o <= ~protect_n_s;
      busy_o <= (next_state != st_idle);
      rx_valid_o <= byte_end;
      if (byte_end)
      begin
        rx_data_o <= rx_shift;
      end
      // Only one data line each way: the single-line serial data mode.
      if (load_byte)
      begin
        tx_shift <= {load_data[BYTE_W-2:0], 1'b0};
        card_data_in_o <= load_data[BYTE_W-1];
        last_byte <= drain_bus.data[LAST_BIT];
        bit_index <= FIRST_BIT_INDEX;
      end
      if (start_new)
      begin
        card_select_n_o <= 1'b0;
      end
      if ((state == st_finish) && tick)
      begin
        card_select_n_o <= SELECT_IDLE;
      end
      // The clock toggles on every tick, so it runs at half the source rate.
      if (rise_tick)
      begin
        card_serial_clock_o <= 1'b1;
        rx_shift <= {rx_shift[BYTE_W-2:0], miso_s};
      end
      if (fall_tick)
      begin
        card_serial_clock_o <= CLOCK_IDLE;
        if (!byte_end)
        begin
          bit_index <= bit_index + 3'h1;
          card_data_in_o <= tx_shift[BYTE_W-1];
          tx_shift <= {tx_shift[BYTE_W-2:0], 1'b0};
        end
      end
    end
  end
endmodule

// ---- card_model.sv ----
`timescale 1ns/1ns
module card_model
(
  // Card pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic di_i,
  output logic do_o,
  // Reply and capture
  input wire logic [7:0] reply_i,
  output logic [7:0] got_o
);
  logic [7:0] sh = 8'h00;
  logic [2:0] n = 3'h0;
  logic last = 1'b0;
  // A released line shows the inverse of its last bit, never a settled value.
  assign do_o = cs_n_i ? ~last : sh[7];
  always @(negedge cs_n_i)
  begin
    sh = reply_i;
    n = 3'h0;
  end
  always @(posedge sclk_i)
    if (!cs_n_i)
    begin
      got_o = {got_o[6:0], di_i};
      last = sh[7];
      n = n + 3'h1;
    end
  always @(negedge sclk_i)
    if (!cs_n_i)
      sh = (n == 3'h0) ? reply_i : {sh[6:0], 1'b0};
endmodule

// ---- memory_card_spi_host_sva.sv ----
`timescale 1ns/1ns
module memory_card_spi_host_sva
(
  // Watched ports
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic card_detect_n_i,
  input wire logic write_protect_n_i,
  input wire logic rx_valid_o,
  input wire logic card_select_n_o,
  input wire logic card_serial_clock_o,
  input wire logic card_data_in_o,
  input wire logic busy_o,
  input wire logic card_present_o,
  input wire logic write_protected_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_idle; card_select_n_o |-> !card_serial_clock_o; endproperty
  property p_mode0; $changed(card_data_in_o) |-> !card_serial_clock_o; endproperty
  property p_half; $changed(card_serial_clock_o) |=> $stable(card_serial_clock_o)[*8]; endproperty
  property p_sel; $fell(card_select_n_o) |-> busy_o; endproperty
  property p_end; $rose(card_select_n_o) |-> ##[0:1] !busy_o; endproperty
  property p_rx; rx_valid_o |-> !card_select_n_o ##1 !rx_valid_o; endproperty
  property p_det; $fell(card_detect_n_i) |-> ##[2:4] card_present_o; endproperty
  property p_wp; $fell(write_protect_n_i) |-> ##[2:4] write_protected_o; endproperty
  a_idle: assert property (p_idle) else $error("clock active while deselected");
  a_mode0: assert property (p_mode0) else $error("data moved with clock high");
  a_half: assert property (p_half) else $error("clock half period short");
  a_sel: assert property (p_sel) else $error("select without busy");
  a_end: assert property (p_end) else $error("busy after select rose");
  a_rx: assert property (p_rx) else $error("bad receive pulse");
  a_det: assert property (p_det) else $error("card not seen");
  a_wp: assert property (p_wp) else $error("protect not seen");
  c_rx: cover property (rx_valid_o);
  c_end: cover property ($rose(card_select_n_o));
  c_det: cover property (card_present_o);
endmodule
bind memory_card_spi_host memory_card_spi_host_sva u_sva (.clk_i, .reset_n_i, .card_detect_n_i,
  .write_protect_n_i, .rx_valid_o, .card_select_n_o, .card_serial_clock_o, .card_data_in_o,
  .busy_o, .card_present_o, .write_protected_o);

// ---- tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  import card_spi_pkg::*;
  logic clk_i = 1'b0, reset_n_i = 1'b0, fast_source_clock_i = 1'b0, slow_source_clock_i = 1'b0;
  logic enable_i = 1'b1, init_active_i = 1'b0, tx_valid_i = 1'b0;
  logic card_detect_n_i = 1'b1, write_protect_n_i = 1'b1;
  logic [WORD_W-1:0] tx_data_i = 9'h000;
  logic [7:0] reply = 8'h3c;
  logic [7:0] got;
  logic [BYTE_W-1:0] rx_data_o;
  logic tx_ready_o, rx_valid_o, card_select_n_o, card_serial_clock_o, card_data_in_o;
  logic card_data_out_i, busy_o, card_present_o, write_protected_o;
  int mismatches = 0, total_checks = 0, cyc;
  always #5 clk_i = ~clk_i;
  always #80 fast_source_clock_i = ~fast_source_clock_i;
  // A half period of whole clock periods keeps the slow edges off the sampling edge.
  always #15620 slow_source_clock_i = ~slow_source_clock_i;
  memory_card_spi_host dut (.clk_i, .reset_n_i, .fast_source_clock_i, .slow_source_clock_i,
    .enable_i, .init_active_i, .tx_valid_i, .tx_data_i, .tx_ready_o, .rx_valid_o, .rx_data_o,
    .card_select_n_o, .card_serial_clock_o, .card_data_in_o, .card_data_out_i,
    .card_detect_n_i, .write_protect_n_i, .busy_o, .card_present_o, .write_protected_o);
  card_model card (.cs_n_i(card_select_n_o), .sclk_i(card_serial_clock_o),
    .di_i(card_data_in_o), .do_o(card_data_out_i), .reply_i(reply), .got_o(got));
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Pushes one word, then leaves a spare cycle since ready lags a full FIFO.
  task automatic push(input logic [8:0] w);
    int k;
    k = 0;
    while (tx_ready_o !== 1'b1 && k < 5000)
    begin
      tick(1);
      k++;
    end
    tx_valid_i = 1'b1;
    tx_data_i = w;
    tick(1);
    tx_valid_i = 1'b0;
    tick(1);
  endtask
  task automatic wait_rx(input int lim);
    cyc = 0;
    while (rx_valid_o !== 1'b1 && cyc < lim)
    begin
      tick(1);
      cyc++;
    end
    chk({8'h00, rx_valid_o}, 9'h001);
  endtask
  task automatic wait_idle(input int lim);
    int k;
    k = 0;
    while (busy_o !== 1'b0 && k < lim)
    begin
      tick(1);
      k++;
    end
    chk({8'h00, card_select_n_o}, 9'h001);
  endtask
  task automatic t_status;
    for (int v = 0; v < 2; v++)
    begin
      card_detect_n_i = v[0];
      write_protect_n_i = v[0];
      tick(5);
      chk({8'h00, card_present_o}, {8'h00, ~v[0]});
      chk({8'h00, write_protected_o}, {8'h00, ~v[0]});
    end
    $display("status test done");
  endtask
  task automatic t_seq;
    push(9'h011);
    push(9'h1c3);
    wait_rx(600);
    chk({8'h00, cyc >= 230 && cyc <= 280}, 9'h001);
    chk({1'b0, rx_data_o}, 9'h03c);
    chk({1'b0, got}, 9'h011);
    tick(1);
    chk({8'h00, card_select_n_o}, 9'h000);
    wait_rx(600);
    chk({1'b0, got}, 9'h0c3);
    wait_idle(200);
    $display("sequence test done");
  endtask
  task automatic t_abort;
    push(9'h077);
    tick(3);
    enable_i = 1'b0;
    wait_rx(600);
    chk({1'b0, got}, 9'h077);
    tick(1);
    wait_idle(200);
    enable_i = 1'b1;
    $display("disable test done");
  endtask
  task automatic t_fifo;
    enable_i = 1'b0;
    for (int i = 0; i < 16; i++)
      push(9'h100 | 9'(i));
    chk({8'h00, tx_ready_o}, 9'h000);
    chk({8'h00, card_select_n_o}, 9'h001);
    enable_i = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      wait_rx(600);
      chk({1'b0, got}, 9'(i));
      tick(1);
    end
    wait_idle(200);
    $display("buffer test done");
  endtask
  task automatic t_slow;
    init_active_i = 1'b1;
    reply = 8'ha6;
    push(9'h15a);
    wait_rx(60000);
    chk({8'h00, cyc > 40000}, 9'h001);
    chk({1'b0, rx_data_o}, 9'h0a6);
    chk({1'b0, got}, 9'h05a);
    tick(1);
    wait_idle(10000);
    init_active_i = 1'b0;
    $display("slow clock test done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    // The slow byte dominates the run, so about 90000 clock cycles is ample.
    #900000;
    mismatches++;
    results;
  end
  initial
  begin
    tick(5);
    reset_n_i = 1'b1;
    tick(2);
    t_status;
    t_seq;
    t_abort;
    t_fifo;
    t_slow;
    results;
  end
endmodule
